//--- asram_pkg.sv
// Package with pin widths, timing figures and cycle counts of the memory port.
package asram_pkg;
  // Word address width and data width of the external memory.
  localparam int unsigned ADDR_W       = 17;
  localparam int unsigned DATA_W       = 16;
  // Clock period of the controller in picoseconds (50 MHz).
  localparam int unsigned CLK_PS       = 20000;
  // Read cycle time, least, in ns.
  localparam int unsigned T_RC_NS      = 45;
  // Output enable low to data valid, longest, in ns.
  localparam int unsigned T_DOE_NS     = 22;
  // Write strobe pulse width, least, in ns.
  localparam int unsigned T_PWE_NS     = 35;
  // Data setup to write end, least, in ns.
  localparam int unsigned T_SD_NS      = 25;
  // Output turn-off after write strobe falls, longest, in ns.
  localparam int unsigned T_HZWE_NS    = 18;
  // Output or byte select high to high impedance, longest, in ns.
  localparam int unsigned T_HZOE_NS    = 18;
  // Least cycle counts, rounded up.
  localparam int unsigned RD_CYC       =
    (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WR_PULSE_NS  =
    (T_PWE_NS > T_SD_NS + T_HZWE_NS) ? T_PWE_NS : T_SD_NS + T_HZWE_NS;
  localparam int unsigned WR_CYC       =
    (WR_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned TURN_CYC     =
    (T_HZOE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Counter width shared by the phase timer.
  localparam int unsigned CNT_W        = 4;
  // Phases of one access.
  typedef enum logic [2:0] {
    ASRAM_IDLE = 3'b000,
    ASRAM_RD   = 3'b001,
    ASRAM_WSET = 3'b010,
    ASRAM_WR   = 3'b011,
    ASRAM_TURN = 3'b100
  } asram_state_t;
endpackage : asram_pkg

//--- asram_tmr_if.sv
// Interface joining the access sequencer to its phase timer.
`timescale 1ns/1ps
interface asram_tmr_if;
  import asram_pkg::*;
  logic             load;   // Pulse that loads a new count.
  logic [CNT_W-1:0] count;  // Cycles to wait after the load.
  logic             done;   // High once the loaded count has run out.
  modport master (output load, output count, input done);
  modport timer  (input load, input count, output done);
endinterface : asram_tmr_if

//--- asram_timer.sv
// Down counter that times each phase of an access.
`timescale 1ns/1ps
module asram_timer
  import asram_pkg::*;
(
  input  wire logic  clk_sys_in,
  input  wire logic  rst_in,
  input  wire logic  ce_in,
  asram_tmr_if.timer tmr
);
  logic [CNT_W-1:0] cnt_reg;   // Cycles still to wait.
  logic [CNT_W-1:0] cnt_next;  // Next value of the counter.

  // A load wins over counting so back to back phases lose no cycle.
  always_comb
  begin
    cnt_next = cnt_reg;
    if (tmr.load)
    begin
      cnt_next = tmr.count;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Registers the counter; the clock enable freezes it.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= '0;
    end
    else if (ce_in)
    begin
      cnt_reg <= cnt_next;
    end
  end

  // Done reads the counter alone: the sequencer loads on done, so
  // gating done with the load would close a combinational loop.
  assign tmr.done = (cnt_reg == '0);
endmodule : asram_timer

//--- asram_host.sv
// Host controller that drives an asynchronous 16-bit static memory.
// How it works
// - Data timed against the write-ending edge.
// - Strobe low time covers setup plus turn-off.
// - Host waits for bus release before driving.
// - Address-only reads keep controls low.
// - Write strobe stays high through every read.
// - Address set on the same edge as select falls.
// - Controls always at definite logic levels.
`timescale 1ns/1ps
module asram_host
  import asram_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,  // Word address width.
  parameter int unsigned DW = DATA_W   // Data width.
)
(
  input  wire logic          clk_sys_in,
  input  wire logic          rst_in,
  input  wire logic          ce_in,
  input  wire logic          req_valid_in,
  input  wire logic          req_write_in,
  input  wire logic [AW-1:0] req_addr_in,
  input  wire logic [DW-1:0] req_wdata_in,
  input  wire logic [1:0]    req_lanes_in,
  output logic               req_ready_out,
  output logic               rsp_valid_out,
  output logic [DW-1:0]      rsp_rdata_out,
  output logic               chip_select_n_out,
  output logic               write_strobe_n_out,
  output logic               output_drive_n_out,
  output logic               upper_lane_select_n_out,
  output logic               lower_lane_select_n_out,
  output logic [AW-1:0]      word_address_out,
  input  wire logic [DW-1:0] data_in,
  output logic [DW-1:0]      data_out,
  output logic               data_oe_n_out
);
  import asram_pkg::*;

  localparam logic [CNT_W-1:0] RD_CNT   = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] WR_CNT   = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);
  localparam logic [CNT_W-1:0] ONE_CNT  = CNT_W'(1);

  asram_tmr_if tmr ();  // Link to the phase timer.

  asram_state_t     st_reg,    st_next;     // Access phase.
  logic             cs_reg,    cs_next;     // Chip select, active low.
  logic             we_reg,    we_next;     // Write strobe, active low.
  logic             oe_reg,    oe_next;     // Output drive, active low.
  logic             ub_reg,    ub_next;     // Upper lane, active low.
  logic             lb_reg,    lb_next;     // Lower lane, active low.
  logic [AW-1:0]    addr_reg,  addr_next;   // Word address pins.
  logic [DW-1:0]    wd_reg,    wd_next;     // Write data pins.
  logic             doe_reg,   doe_next;    // Data enable, low drives.
  logic             rdy_reg,   rdy_next;    // Ready for a request.
  logic             rv_reg,    rv_next;     // Read data valid pulse.
  logic [DW-1:0]    rd_reg,    rd_next;     // Captured read data.
  logic             ld;                     // Timer load.
  logic [CNT_W-1:0] ld_cnt;                 // Timer count.

  assign tmr.load  = ld;
  assign tmr.count = ld_cnt;

  asram_timer u_timer (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .tmr        (tmr)
  );

  // Sequencer: every control pin is a flop, always at a firm level.
  always_comb
  begin
    st_next      = st_reg;
    cs_next      = cs_reg;
    we_next      = we_reg;
    oe_next      = oe_reg;
    ub_next      = ub_reg;
    lb_next      = lb_reg;
    addr_next    = addr_reg;
    wd_next      = wd_reg;
    doe_next     = doe_reg;
    rdy_next     = rdy_reg;
    rv_next      = 1'b0;
    rd_next      = rd_reg;
    ld           = 1'b0;
    ld_cnt       = ONE_CNT;
    case (st_reg)
      ASRAM_IDLE:
      begin
        // Deselected idle keeps the memory in standby.
        if (req_valid_in && rdy_reg && (req_lanes_in != 2'b00))
        begin
          // Address is set up with, never after, select falling.
          addr_next = req_addr_in;
          cs_next   = 1'b0;
          ub_next   = ~req_lanes_in[1];
          lb_next   = ~req_lanes_in[0];
          rdy_next  = 1'b0;
          ld        = 1'b1;
          if (req_write_in)
          begin
            // Output drive stays off so the memory never drives.
            oe_next  = 1'b1;
            wd_next  = req_wdata_in;
            doe_next = 1'b0;
            ld_cnt   = ONE_CNT;
            st_next  = ASRAM_WSET;
          end
          else
          begin
            we_next = 1'b1;
            oe_next = 1'b0;
            ld_cnt  = RD_CNT;
            st_next = ASRAM_RD;
          end
        end
      end
      ASRAM_RD:
      begin
        if (tmr.done)
        begin
          // Lanes not asked for float at the memory, so mask them.
          rd_next[7:0]     = lb_reg ? 8'h00 : data_in[7:0];
          rd_next[DW-1:8]  = ub_reg ? '0 : data_in[DW-1:8];
          rv_next          = 1'b1;
          // Stay selected for an address-only next read.
          if (req_valid_in && !req_write_in
              && (req_lanes_in == {~ub_reg, ~lb_reg}))
          begin
            addr_next = req_addr_in;
            ld        = 1'b1;
            ld_cnt    = RD_CNT;
          end
          else
          begin
            cs_next      = 1'b1;
            oe_next      = 1'b1;
            ub_next      = 1'b1;
            lb_next      = 1'b1;
            ld           = 1'b1;
            ld_cnt       = TURN_CNT;
            st_next      = ASRAM_TURN;
          end
        end
      end
      ASRAM_WSET:
      begin
        // Strobe falls last, so select and the asked-for lane selects are already low.
        if (tmr.done)
        begin
          we_next = 1'b0;
          ld      = 1'b1;
          ld_cnt  = WR_CNT;
          st_next = ASRAM_WR;
        end
      end
      ASRAM_WR:
      begin
        if (tmr.done)
        begin
          // Only the strobe rises; data, select and address hold two
          // more cycles so this edge alone ends the write.
          we_next = 1'b1;
          ld      = 1'b1;
          ld_cnt  = ONE_CNT;
          st_next = ASRAM_TURN;
        end
      end
      ASRAM_TURN:
      begin
        if (tmr.done)
        begin
          // Releases select, lanes and the data pins on one edge.
          cs_next  = 1'b1;
          ub_next  = 1'b1;
          lb_next  = 1'b1;
          doe_next = 1'b1;
          rdy_next = 1'b1;
          st_next  = ASRAM_IDLE;
        end
      end
      default:
      begin
        st_next = ASRAM_IDLE;
      end
    endcase
  end

  // Registers the sequencer; reset leaves the memory deselected.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg      <= ASRAM_IDLE;
      cs_reg      <= 1'b1;
      we_reg      <= 1'b1;
      oe_reg      <= 1'b1;
      ub_reg      <= 1'b1;
      lb_reg      <= 1'b1;
      addr_reg    <= '0;
      wd_reg      <= '0;
      doe_reg     <= 1'b1;
      rdy_reg     <= 1'b1;
      rv_reg      <= 1'b0;
      rd_reg      <= '0;
    end
    else if (ce_in)
    begin
      st_reg      <= st_next;
      cs_reg      <= cs_next;
      we_reg      <= we_next;
      oe_reg      <= oe_next;
      ub_reg      <= ub_next;
      lb_reg      <= lb_next;
      addr_reg    <= addr_next;
      wd_reg      <= wd_next;
      doe_reg     <= doe_next;
      rdy_reg     <= rdy_next;
      rv_reg      <= rv_next;
      rd_reg      <= rd_next;
    end
  end

  // All pin outputs come straight from flops.
  assign req_ready_out           = rdy_reg;
  assign rsp_valid_out           = rv_reg;
  assign rsp_rdata_out           = rd_reg;
  assign chip_select_n_out       = cs_reg;
  assign write_strobe_n_out      = we_reg;
  assign output_drive_n_out      = oe_reg;
  assign upper_lane_select_n_out = ub_reg;
  assign lower_lane_select_n_out = lb_reg;
  assign word_address_out        = addr_reg;
  assign data_out                = wd_reg;
  assign data_oe_n_out           = doe_reg;
endmodule : asram_host

//--- asram_host_properties.sv
// Pin protocol checker for the static memory host.
`timescale 1ns/1ps
module asram_host_properties
  import asram_pkg::*;
#(
  parameter int unsigned DW = DATA_W  // Data width.
)
(
  input wire logic          clk_sys_in,
  input wire logic          rst_in,
  input wire logic          ce_in,
  input wire logic          req_ready_out,
  input wire logic          rsp_valid_out,
  input wire logic          chip_select_n_out,
  input wire logic          write_strobe_n_out,
  input wire logic          output_drive_n_out,
  input wire logic          upper_lane_select_n_out,
  input wire logic          lower_lane_select_n_out,
  input wire logic [DW-1:0] data_out,
  input wire logic          data_oe_n_out
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_sys_in); endclocking
  // A low clock enable stretches every phase, so checks pause then.
  default disable iff (rst_in || !ce_in);
  // Host drive and memory output drive must never overlap.
  a_no_bus_clash:
    assert property (!data_oe_n_out |-> output_drive_n_out)
    else $error("host drives pins with output drive on");
  a_strobe_qualified:
    assert property (!write_strobe_n_out |-> !chip_select_n_out
      && !(upper_lane_select_n_out && lower_lane_select_n_out))
    else $error("strobe low without select or lane");
  a_write_oe_off:
    assert property (!write_strobe_n_out |-> output_drive_n_out
      && !data_oe_n_out)
    else $error("write without host drive or with output drive");
  a_read_strobe_high:
    assert property (!output_drive_n_out |-> write_strobe_n_out)
    else $error("strobe low during read");
  // A short strobe would not cover setup plus turn-off time.
  a_strobe_width:
    assert property ($fell(write_strobe_n_out) |->
      !write_strobe_n_out [*3])
    else $error("strobe low time too short");
  a_data_hold_end:
    assert property (!write_strobe_n_out |=> $stable(data_out)
      && !data_oe_n_out)
    else $error("write data moved before write end");
  a_select_after_end:
    assert property ($rose(write_strobe_n_out) |-> !chip_select_n_out
      && $stable({upper_lane_select_n_out, lower_lane_select_n_out}))
    else $error("select or lanes released with the strobe");
  a_read_answer:
    assert property ($fell(output_drive_n_out) |-> ##4 rsp_valid_out)
    else $error("read answer not on time");
  a_rsp_one_cycle:
    assert property (rsp_valid_out |=> !rsp_valid_out)
    else $error("response longer than one cycle");
endmodule : asram_host_properties
bind asram_host asram_host_properties #(.DW(DW)) i_asram_host_properties
  (.clk_sys_in, .rst_in, .ce_in, .req_ready_out, .rsp_valid_out,
   .chip_select_n_out, .write_strobe_n_out, .output_drive_n_out,
   .upper_lane_select_n_out, .lower_lane_select_n_out, .data_out,
   .data_oe_n_out);

//--- asram_mem_model.sv
// Behavioural model of the asynchronous 16-bit static memory.
`timescale 1ns/1ps
module asram_mem_model
  import asram_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              cs_n_in,
  input  wire logic              we_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              ub_n_in,
  input  wire logic              lb_n_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] host_data_in,
  input  wire logic              host_oe_n_in,
  output logic      [DATA_W-1:0] pins_out,
  output logic                   clash_out
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Full array.
  logic [DATA_W-1:0] noise_reg = 16'hA5C3;  // Undriven pin pattern.
  logic              rd, wr, drv_hi, drv_lo;
  initial foreach (mem[i]) mem[i] = 16'h0;
  // Undriven pins change every cycle so a stale value never passes.
  always @(posedge clk_in) noise_reg <= noise_reg + 16'h5A3D;
  assign rd = !cs_n_in && we_n_in && !oe_n_in;
  assign wr = !cs_n_in && !we_n_in;
  assign drv_hi = rd && !ub_n_in;
  assign drv_lo = rd && !lb_n_in;
  // Level write: only during the overlap, ends at first release.
  always @*
  begin
    if (wr && !lb_n_in) mem[addr_in][7:0] = host_data_in[7:0];
    if (wr && !ub_n_in) mem[addr_in][15:8] = host_data_in[15:8];
  end
  // Resolve each pin from host drive, memory drive or noise.
  always @*
    for (int i = 0; i < DATA_W; i++)
      if (!host_oe_n_in) pins_out[i] = host_data_in[i];
      else if (i < 8 ? drv_lo : drv_hi) pins_out[i] = mem[addr_in][i];
      else pins_out[i] = noise_reg[i];
  assign clash_out = !host_oe_n_in && (drv_hi || drv_lo);
endmodule : asram_mem_model

//--- test_asram_host.sv
// Self-checking testbench of the static memory host.
`timescale 1ns/1ps
module test_asram_host;
  import asram_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0;
  logic [ADDR_W-1:0] req_addr_in = 17'h0;
  logic [DATA_W-1:0] req_wdata_in = 16'h0, data_in, data_out, rsp_rdata_out;
  logic [1:0] req_lanes_in = 2'h0;
  logic req_ready_out, rsp_valid_out, chip_select_n_out, data_oe_n_out;
  logic write_strobe_n_out, output_drive_n_out, clash;
  logic upper_lane_select_n_out, lower_lane_select_n_out;
  logic [ADDR_W-1:0] word_address_out;
  logic [DATA_W-1:0] exp_q [$];                  // Expected read words.
  logic [DATA_W-1:0] shadow [0:(1<<ADDR_W)-1];   // Expected memory.
  int bad_count = 0, samples_checked = 0, seed = 32'hC26F919C, r;
  logic ce_in = 1'b1;                            // Clock enable stimulus.
  logic [ADDR_W-1:0] spot;                       // Address under test.
  logic [DATA_W-1:0] exp_w;                      // Expected read word.
  initial foreach (shadow[i]) shadow[i] = 16'h0;
  always #10 clk_sys_in = ~clk_sys_in;
  asram_host i_asram_host (.clk_sys_in, .rst_in, .ce_in,
    .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
    .req_lanes_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out,
    .chip_select_n_out, .write_strobe_n_out, .output_drive_n_out,
    .upper_lane_select_n_out, .lower_lane_select_n_out,
    .word_address_out, .data_in, .data_out, .data_oe_n_out);
  asram_mem_model i_asram_mem_model (.clk_in(clk_sys_in),
    .cs_n_in(chip_select_n_out), .we_n_in(write_strobe_n_out),
    .oe_n_in(output_drive_n_out), .ub_n_in(upper_lane_select_n_out),
    .lb_n_in(lower_lane_select_n_out), .addr_in(word_address_out),
    .host_data_in(data_out), .host_oe_n_in(data_oe_n_out),
    .pins_out(data_in), .clash_out(clash));
  // Compare one value and count it.
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Print the verdict and stop.
  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  // Hand one request over once ready; note reads and writes expected.
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    while (req_ready_out !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 50) bad_count++;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_lanes_in <= ln;
    if (wr && ln[0]) shadow[a][7:0] = d[7:0];
    if (wr && ln[1]) shadow[a][15:8] = d[15:8];
    if (!wr) exp_q.push_back(shadow[a] & {{8{ln[1]}}, {8{ln[0]}}});
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
  endtask : issue
  // Monitor: every answer takes the oldest note; pins never clash.
  always @(negedge clk_sys_in)
  begin
    check(16'(clash), 16'h0);
    if (rsp_valid_out === 1'b1)
    begin
      exp_w = exp_q.size() ? exp_q.pop_front() : ~rsp_rdata_out;
      check(rsp_rdata_out, exp_w);
    end
  end
  // The run should need well under 20000 cycles.
  initial
  begin
    #400000;
    bad_count++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // Boundary words with every lane choice, write then read back.
    for (int i = 0; i < 6; i++)
    begin
      spot = i[0] ? 17'h1FFFF : 17'h0;
      issue(1'b1, spot, 16'($random(seed)), 2'(i % 3 + 1));
      for (int k = 1; k < 4; k++)
        issue(1'b0, spot, 16'h0, 2'(k));
    end
    // Back-to-back random mix over a small pool so words are reused.
    repeat (200)
    begin
      r = $random(seed);
      issue(r[4], {13'h1FFF, r[8:5]}, 16'($random(seed)),
            r[1:0] == 2'h0 ? 2'h3 : r[1:0]);
    end
    // A read offered on the data sample edge chains a second address
    // while select and output drive stay low.
    issue(1'b0, 17'h1FFF3, 16'h0, 2'h3);
    repeat (3) @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_addr_in  <= 17'h1FFF7;
    exp_q.push_back(shadow[17'h1FFF7]);
    @(posedge clk_sys_in) req_valid_in <= 1'b0;
    @(negedge clk_sys_in) check(16'(chip_select_n_out), 16'h0);
    // Clock enable low freezes a read, so its answer comes late.
    issue(1'b0, 17'h1FFFF, 16'h0, 2'h1);
    ce_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    ce_in <= 1'b1;
    @(negedge clk_sys_in) check(16'(rsp_valid_out), 16'h0);
    // No lane asked for: request ignored, memory left unselected.
    issue(1'b1, 17'h5, 16'hFFFF, 2'h0);
    repeat (4) @(negedge clk_sys_in) check(16'(chip_select_n_out), 16'h1);
    // Reset in mid-run leaves the pins idle and the memory intact.
    @(posedge clk_sys_in) rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check(16'({chip_select_n_out, write_strobe_n_out}), 16'h3);
    check(16'(data_oe_n_out), 16'h1);
    rst_in <= 1'b0;
    issue(1'b0, 17'h1FFFF, 16'h0, 2'h3);
    issue(1'b0, 17'h5, 16'h0, 2'h3);
    repeat (20) @(posedge clk_sys_in);
    check(16'(exp_q.size()), 16'h0);
    end_sim();
  end
endmodule : test_asram_host
